// file: include/rx_filter_defines.vh
// Purpose: constants for the receive frame type/version filter
// Assumes: avalon-mm word addressing, 8-bit registers in the low byte of a 32-bit word
// Notes:   printed offsets are register indices; byte address is four times the index
//
// What this block does
// - compare frame version with version selector
// - selector 00 accepts versions zero to three
// - selector 01 accepts version zero only
// - selector 10 accepts version one only
// - selector 11 accepts versions zero and one
// - versions two, three parse security like one
// - snoop bit: promiscuous indication, normal acknowledge
// - reserved types rejected when reserved bit clear
// - reserved bit set: only length 5..127 checked
// - command frames gated by command accept bit
// - ack frames gated by ack accept bit
// - data frames gated by data accept bit
// - beacon frames gated by beacon accept bit
// - second network frequency from integer and fraction
// - integer register bits 7..5 reserved
// - fraction in two bytes at 0x11, lsb first
`ifndef RX_FILTER_DEFINES_VH
`define RX_FILTER_DEFINES_VH

// --------------------------------------------------------------
// register indices
// --------------------------------------------------------------
`define IDX_FRAME_FILTER   6'h0f
`define IDX_FREQ_INTEGER   6'h10
`define IDX_FREQ_FRAC_LO   6'h11
`define IDX_FREQ_FRAC_HI   6'h12
`define IDX_FILTER_STATUS  6'h13

// --------------------------------------------------------------
// filter register fields and reset values
// --------------------------------------------------------------
`define FLT_VER_HI         7
`define FLT_VER_LO         6
`define FLT_SNOOP_ACK      5
`define FLT_RSVD_ACCEPT    4
`define FLT_CMD_ACCEPT     3
`define FLT_ACK_ACCEPT     2
`define FLT_DATA_ACCEPT    1
`define FLT_BEACON_ACCEPT  0
`define FLT_RESET          8'h0f
`define INT_RESET          8'h00
`define INT_FIELD_MASK     8'h1f
`define FRAC_RESET         8'hff

// --------------------------------------------------------------
// frame types, version selector codes, length limits
// --------------------------------------------------------------
`define FT_BEACON          3'h0
`define FT_DATA            3'h1
`define FT_ACK             3'h2
`define FT_CMD             3'h3
`define VSEL_ANY           2'h0
`define VSEL_V0            2'h1
`define VSEL_V1            2'h2
`define VSEL_V0_V1         2'h3
`define LEN_MIN            7'h05
`define LEN_MAX            7'h7f
`define FREQ_OFFSET        7'h40
`define FREQ_REF_MHZ       32

`endif

// file: core/rx_frame_classify.v
// Purpose: decide type/version acceptance of one frame control field
// Assumes: combinational, used by the filter core on the same clock
// Notes:   address and pan checks belong elsewhere; this only covers type and version
`timescale 1ns/1ps
`include "rx_filter_defines.vh"

module rx_frame_classify (
    input  wire [15:0] i_fcf,
    input  wire [6:0]  i_frame_len,
    input  wire [7:0]  i_filter_cfg,
    output reg         o_type_ok,
    output reg         o_version_ok,
    output reg         o_reserved_type,
    output wire        o_sec_hdr_v1
);

    wire [2:0] frame_type;
    wire [1:0] frame_ver;
    wire [1:0] ver_sel;
    wire       len_ok;

    assign frame_type = i_fcf[2:0];
    assign frame_ver  = i_fcf[13:12];
    assign ver_sel    = i_filter_cfg[`FLT_VER_HI:`FLT_VER_LO];
    assign len_ok     = (i_frame_len >= `LEN_MIN) && (i_frame_len <= `LEN_MAX);
    assign o_sec_hdr_v1 = (frame_ver != 2'h0);

    // type gate, one accept bit per defined type; reserved types share one accept bit plus the length check
    always @* begin
        o_reserved_type = 1'b0;
        case (frame_type)
            `FT_BEACON: o_type_ok = i_filter_cfg[`FLT_BEACON_ACCEPT];
            `FT_DATA:   o_type_ok = i_filter_cfg[`FLT_DATA_ACCEPT];
            `FT_ACK:    o_type_ok = i_filter_cfg[`FLT_ACK_ACCEPT];
            `FT_CMD:    o_type_ok = i_filter_cfg[`FLT_CMD_ACCEPT];
            default: begin
                o_reserved_type = 1'b1;
                o_type_ok = i_filter_cfg[`FLT_RSVD_ACCEPT] & len_ok;
            end
        endcase
    end

    // version gate; reserved types bypass it entirely
    always @* begin
        case (ver_sel)
            `VSEL_ANY:  o_version_ok = 1'b1;
            `VSEL_V0:   o_version_ok = (frame_ver == 2'h0);
            `VSEL_V1:   o_version_ok = (frame_ver == 2'h1);
            default:    o_version_ok = (frame_ver == 2'h0) || (frame_ver == 2'h1);
        endcase
        if (o_reserved_type) begin
            o_version_ok = 1'b1;
        end
    end

endmodule

// file: core/rx_frame_filter.v
// Purpose: receive frame type/version filter with its register bank
// Assumes: frames arrive as one control field plus length strobe per frame
// Notes:   avalon-mm slave answers every access with one wait cycle
`timescale 1ns/1ps
`include "rx_filter_defines.vh"

module rx_frame_filter (
    input  wire        i_mclk,
    input  wire        i_sys_rst,
    // avalon-mm slave
    input  wire [5:0]  i_avs_address,
    input  wire        i_avs_read,
    input  wire        i_avs_write,
    input  wire [31:0] i_avs_writedata,
    input  wire [3:0]  i_avs_byteenable,
    output reg  [31:0] o_avs_readdata,
    output reg         o_avs_waitrequest,
    // frame from the receive path
    input  wire        i_frame_valid,
    input  wire [15:0] i_frame_fcf,
    input  wire [6:0]  i_frame_len,
    input  wire        i_promisc_pass,
    input  wire        i_normal_pass,
    // results
    output reg         o_data_ind,
    output reg         o_ack_req,
    output reg         o_sec_hdr_v1,
    output reg  [4:0]  o_freq_int,
    output reg  [15:0] o_freq_frac
);

    // ----------------------------------------------------------
    // registers
    // ----------------------------------------------------------
    reg  [7:0]  filter_r;
    reg  [7:0]  freq_int_r;
    reg  [15:0] freq_frac_r;
    reg  [7:0]  last_status_r;
    reg         ack_phase_r;
    reg  [31:0] rdata_nxt;
    reg         hit_nxt;

    wire        type_ok;
    wire        version_ok;
    wire        reserved_type;
    wire        sec_v1;
    wire        access;
    wire        accepted;
    wire        ind_nxt;
    wire        ack_nxt;

    rx_frame_classify u_classify (
        .i_fcf           (i_frame_fcf),
        .i_frame_len     (i_frame_len),
        .i_filter_cfg    (filter_r),
        .o_type_ok       (type_ok),
        .o_version_ok    (version_ok),
        .o_reserved_type (reserved_type),
        .o_sec_hdr_v1    (sec_v1)
    );

    // ----------------------------------------------------------
    // bus handshake
    // ----------------------------------------------------------
    // one wait cycle keeps read data registered without a combinational path
    assign access = (i_avs_read | i_avs_write) & ~ack_phase_r;

    always @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ack_phase_r       <= 1'b0;
            o_avs_waitrequest <= 1'b1;
        end else begin
            ack_phase_r       <= access;
            o_avs_waitrequest <= ~access;
        end
    end

    // read mux; unmapped indices read zero
    always @* begin
        rdata_nxt = 32'h0000_0000;
        hit_nxt   = 1'b1;
        case (i_avs_address)
            `IDX_FRAME_FILTER:  rdata_nxt[7:0] = filter_r;
            `IDX_FREQ_INTEGER:  rdata_nxt[7:0] = freq_int_r & `INT_FIELD_MASK;
            `IDX_FREQ_FRAC_LO:  rdata_nxt[7:0] = freq_frac_r[7:0];
            `IDX_FREQ_FRAC_HI:  rdata_nxt[7:0] = freq_frac_r[15:8];
            `IDX_FILTER_STATUS: rdata_nxt[7:0] = last_status_r;
            default:            hit_nxt = 1'b0;
        endcase
    end

    always @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_avs_readdata <= 32'h0000_0000;
        end else if (access && i_avs_read) begin
            o_avs_readdata <= hit_nxt ? rdata_nxt : 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------
    // register writes
    // ----------------------------------------------------------
    // writes land on the answer edge, the one where the master sees waitrequest low,
    // so register and handshake change together; only byte lane 0 matters
    always @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            filter_r    <= `FLT_RESET;
            // parked value, kept while the second network is idle
            freq_int_r  <= `INT_RESET;
            freq_frac_r <= {`FRAC_RESET, `FRAC_RESET};
        end else if (ack_phase_r && i_avs_write && i_avs_byteenable[0]) begin
            case (i_avs_address)
                `IDX_FRAME_FILTER: filter_r <= i_avs_writedata[7:0];
                `IDX_FREQ_INTEGER: freq_int_r <= i_avs_writedata[7:0] & `INT_FIELD_MASK;
                `IDX_FREQ_FRAC_LO: freq_frac_r[7:0] <= i_avs_writedata[7:0];
                `IDX_FREQ_FRAC_HI: freq_frac_r[15:8] <= i_avs_writedata[7:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------
    // frame decision
    // ----------------------------------------------------------
    assign accepted = type_ok & version_ok;
    assign ack_nxt  = accepted & (reserved_type | i_normal_pass);
    assign ind_nxt  = filter_r[`FLT_SNOOP_ACK] ? (accepted & (reserved_type | i_promisc_pass))
                                               : ack_nxt;

    // indication and ack are one-cycle pulses, one cycle after the frame strobe
    always @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_data_ind    <= 1'b0;
            o_ack_req     <= 1'b0;
            o_sec_hdr_v1  <= 1'b0;
            last_status_r <= 8'h00;
        end else begin
            o_data_ind <= i_frame_valid & ind_nxt;
            // acknowledge never requested for an ack frame itself
            o_ack_req  <= i_frame_valid & ack_nxt & (i_frame_fcf[2:0] != `FT_ACK);
            if (i_frame_valid) begin
                o_sec_hdr_v1  <= sec_v1;
                last_status_r <= {3'h0, reserved_type, version_ok, type_ok, ind_nxt, ack_nxt};
            end
        end
    end

    // ----------------------------------------------------------
    // second network frequency word
    // ----------------------------------------------------------
    // synthesizer word export
    // F = ((int + 64) + frac/65536) * 32 MHz; synthesizer adds the offset
    always @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_freq_int  <= 5'h00;
            o_freq_frac <= 16'hffff;
        end else begin
            o_freq_int  <= freq_int_r[4:0];
            o_freq_frac <= freq_frac_r;
        end
    end

endmodule

// file: dv/rx_frame_filter_chk.sv
// Purpose: bus and filter timing checks
// Assumes: filter setting shadowed from writes that land
// Notes:   sees top-level ports only
`timescale 1ns/1ps
`include "rx_filter_defines.vh"
module rx_frame_filter_chk (
    input wire        i_mclk,
    input wire        i_sys_rst,
    input wire [5:0]  i_avs_address,
    input wire        i_avs_read,
    input wire        i_avs_write,
    input wire [31:0] i_avs_writedata,
    input wire [3:0]  i_avs_byteenable,
    input wire        o_avs_waitrequest,
    input wire        i_frame_valid,
    input wire [15:0] i_frame_fcf,
    input wire        i_normal_pass,
    input wire        o_data_ind,
    input wire        o_ack_req,
    input wire        o_sec_hdr_v1
);
    reg  [7:0] cfg_r;
    wire [1:0] ver = i_frame_fcf[13:12];
    wire [2:0] ft = i_frame_fcf[2:0];
    wire [1:0] sel = cfg_r[7:6];
    wire       ver_ok = (sel == 2'h0) | (sel[0] & ver == 2'h0) | (sel[1] & ver == 2'h1);
    wire       no_out = !o_data_ind && !o_ack_req;
    // shadow only landed writes, so a refused write cannot skew the gates
    always @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst)
            cfg_r <= `FLT_RESET;
        else if (i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0]
                 && i_avs_address == `IDX_FRAME_FILTER)
            cfg_r <= i_avs_writedata[7:0];
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    a_wait_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
        |=> !o_avs_waitrequest) else $error("access not answered after one wait");
    a_wait_single: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_ind_cause: assert property (o_data_ind |-> $past(i_frame_valid))
        else $error("indication without a frame");
    a_ack_cause: assert property (o_ack_req |-> $past(i_frame_valid)
        && ($past(i_normal_pass) || $past(ft[2]))) else $error("ack without a pass");
    a_ack_no_ack: assert property (i_frame_valid && ft == `FT_ACK |=> !o_ack_req)
        else $error("ack frame acknowledged");
    a_type_gate: assert property (i_frame_valid && !ft[2] && !cfg_r[ft] |=> no_out)
        else $error("disabled frame type passed");
    a_rsvd_reject: assert property (i_frame_valid && ft[2] && !cfg_r[4] |=> no_out)
        else $error("reserved frame type passed");
    a_version_gate: assert property (i_frame_valid && !ft[2] && !ver_ok |=> no_out)
        else $error("frame version not filtered");
    a_sec_hdr: assert property (i_frame_valid |=> o_sec_hdr_v1 == ($past(ver) != 2'h0))
        else $error("security header parse wrong");
endmodule
bind rx_frame_filter rx_frame_filter_chk u_chk (
    .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable), .o_avs_waitrequest(o_avs_waitrequest),
    .i_frame_valid(i_frame_valid), .i_frame_fcf(i_frame_fcf), .i_normal_pass(i_normal_pass),
    .o_data_ind(o_data_ind), .o_ack_req(o_ack_req), .o_sec_hdr_v1(o_sec_hdr_v1)
);

// file: dv/rx_path_model.sv
// Purpose: receive path feeding parsed frames to the filter
// Assumes: frames queued by the bench, sent back to back
// Notes:   idle lines invert every cycle so stale values never pass
`timescale 1ns/1ps
module rx_path_model (
    input  wire        i_mclk,
    output reg         o_valid,
    output reg  [15:0] o_fcf,
    output reg  [6:0]  o_len,
    output reg         o_promisc_pass,
    output reg         o_normal_pass
);
    logic [25:0] frame_q[$];
    initial begin
        o_valid = 1'b0;
        {o_normal_pass, o_promisc_pass, o_len, o_fcf} = 26'h0;
    end
    // one frame per cycle while queued, a changing pattern otherwise
    always @(posedge i_mclk) begin
        if (frame_q.size() > 0) begin
            o_valid <= 1'b1;
            {o_normal_pass, o_promisc_pass, o_len, o_fcf} <= frame_q.pop_front();
        end else begin
            o_valid <= 1'b0;
            {o_normal_pass, o_promisc_pass, o_len, o_fcf} <=
                ~{o_normal_pass, o_promisc_pass, o_len, o_fcf};
        end
    end
endmodule

// file: dv/test_rx_frame_filter.sv
// Purpose: self-checking bench for the frame filter
// Assumes: requests held until waitrequest low, results one cycle after a frame
// Notes:   expectations are queued by the driver, popped by the monitor
`timescale 1ns/1ps
`include "rx_filter_defines.vh"
module test_rx_frame_filter;
    reg         i_mclk = 1'b0;
    reg         i_sys_rst = 1'b1;
    reg  [5:0]  i_avs_address = 6'h00;
    reg         i_avs_read = 1'b0;
    reg         i_avs_write = 1'b0;
    reg  [31:0] i_avs_writedata = 32'h0;
    reg  [3:0]  i_avs_byteenable = 4'h0;
    wire [31:0] o_avs_readdata;
    wire        o_avs_waitrequest, fr_valid, fr_pp, fr_np, o_data_ind, o_ack_req, o_sec_hdr_v1;
    wire [15:0] fr_fcf, o_freq_frac;
    wire [6:0]  fr_len;
    wire [4:0]  o_freq_int;
    integer     mismatches = 0, checked = 0, cyc = 0, seed = 46417, i, k;
    reg  [2:0]  exp_q[$];
    reg  [31:0] q, r;
    reg  [15:0] fcf;
    reg  [7:0]  cfg;
    reg         v_d = 1'b0;
    initial forever #2.5 i_mclk = ~i_mclk;
    rx_frame_filter u_dut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
        .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
        .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
        .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
        .i_frame_valid(fr_valid), .i_frame_fcf(fr_fcf), .i_frame_len(fr_len),
        .i_promisc_pass(fr_pp), .i_normal_pass(fr_np), .o_data_ind(o_data_ind),
        .o_ack_req(o_ack_req), .o_sec_hdr_v1(o_sec_hdr_v1), .o_freq_int(o_freq_int),
        .o_freq_frac(o_freq_frac));
    rx_path_model u_rx (.i_mclk(i_mclk), .o_valid(fr_valid), .o_fcf(fr_fcf), .o_len(fr_len),
        .o_promisc_pass(fr_pp), .o_normal_pass(fr_np));
    task end_sim;
        if (mismatches == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input string nm, input [31:0] ex, input [31:0] got);
        checked = checked + 1;
        if (got !== ex) begin
            mismatches = mismatches + 1;
            $display("ERROR %0s expected %h seen %h", nm, ex, got);
        end
    endtask
    // request held until waitrequest is sampled low, released after it
    task bus(input w, input [5:0] a, input [7:0] d, input [3:0] be);
        @(posedge i_mclk);
        {i_avs_write, i_avs_read, i_avs_address, i_avs_byteenable} <= {w, !w, a, be};
        i_avs_writedata <= {24'h0, d};
        // no cycle count assumed; waitrequest sampled low ends this wait, only the bench timeout ends a hang
        while (o_avs_waitrequest !== 1'b0)
            @(posedge i_mclk);
        q = o_avs_readdata;
        {i_avs_write, i_avs_read} <= 2'b00;
        chk("waitrequest", 32'h0, {31'h0, o_avs_waitrequest});
    endtask
    task rd(input [5:0] a, input [7:0] ex);
        bus(1'b0, a, 8'h00, 4'h1);
        chk("readdata", {24'h0, ex}, q);
    endtask
    function [2:0] exp_of(input [7:0] c, input [15:0] f, input [6:0] l, input p, input m);
        reg base;
        begin
            base = (c[7:6] == 2'h0) | (c[6] & f[13:12] == 2'h0) | (c[7] & f[13:12] == 2'h1);
            base = base & !f[2] & c[f[2:0]];
            if (f[2])
                exp_of = {{2{c[4] & l >= `LEN_MIN}}, f[13:12] != 2'h0};
            else
                exp_of = {base & (c[5] ? p : m), base & m & f[2:0] != `FT_ACK, f[13:12] != 2'h0};
        end
    endfunction
    // monitor pops one note per result; a hang ends the run
    always @(posedge i_mclk) begin
        if (v_d)
            chk("ind_ack_sec", {29'h0, exp_q.pop_front()},
                {29'h0, o_data_ind, o_ack_req, o_sec_hdr_v1});
        v_d <= fr_valid;
        cyc = cyc + 1;
        if (cyc == 20000) begin
            mismatches = mismatches + 1;
            end_sim;
        end
    end
    initial begin
        repeat (3) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        rd(`IDX_FRAME_FILTER, `FLT_RESET);
        rd(`IDX_FREQ_INTEGER, `INT_RESET);
        rd(`IDX_FREQ_FRAC_LO, `FRAC_RESET);
        chk("freq_frac", 32'hffff, {16'h0, o_freq_frac});
        bus(1'b1, `IDX_FREQ_INTEGER, 8'hff, 4'h1);
        bus(1'b1, `IDX_FREQ_FRAC_LO, 8'h34, 4'h1);
        bus(1'b1, `IDX_FREQ_FRAC_HI, 8'h12, 4'h1);
        bus(1'b1, `IDX_FREQ_FRAC_HI, 8'h56, 4'h0);
        bus(1'b1, 6'h2a, 8'h77, 4'h1);
        rd(`IDX_FREQ_INTEGER, `INT_FIELD_MASK);
        rd(`IDX_FREQ_FRAC_HI, 8'h12);
        rd(6'h2a, 8'h00);
        chk("freq_int", 32'h1f, {27'h0, o_freq_int});
        chk("freq_frac", 32'h1234, {16'h0, o_freq_frac});
        // dual network unused here, so the integer goes back to its parked value
        bus(1'b1, `IDX_FREQ_INTEGER, `INT_RESET, 4'h1);
        rd(`IDX_FREQ_INTEGER, `INT_RESET);
        // every type and version under each selector, frames back to back
        for (k = 0; k < 16; k = k + 1) begin
            r = $random(seed);
            cfg = {k[1:0], r[5:0]};
            bus(1'b1, `IDX_FRAME_FILTER, cfg, 4'h1);
            for (i = 0; i < 32; i = i + 1) begin
                r = $random(seed);
                fcf = (r[15:0] & ~16'h3007) | {2'h0, i[1:0], 9'h0, i[4:2]};
                exp_q.push_back(exp_of(cfg, fcf, r[22:16], r[23], r[24]));
                u_rx.frame_q.push_back({r[24:23], r[22:16], fcf});
            end
            while (u_rx.frame_q.size() > 0 || fr_valid)
                @(posedge i_mclk);
            @(posedge i_mclk);
        end
        rd(`IDX_FRAME_FILTER, cfg);
        // last frame was reserved type 7, version 3: only the reserved accept bit and length gate vary
        rd(`IDX_FILTER_STATUS, {5'h03, {3{cfg[4] & r[22:16] >= `LEN_MIN}}});
        end_sim;
    end
endmodule
